// File: common/rt_output_mode_control_defines.svh
`ifndef RT_OUTPUT_MODE_CONTROL_DEFINES_SVH
`define RT_OUTPUT_MODE_CONTROL_DEFINES_SVH

`define CHROMA_CONTROL_TWO_OFFSET      8'h10
`define MODE_DELAY_CONTROL_OFFSET      8'h11
`define REALTIME_OUTPUT_SELECT_OFFSET  8'h12

`define CHROMA_CONTROL_TWO_RESET       8'h00
`define MODE_DELAY_CONTROL_RESET       8'h00
`define REALTIME_OUTPUT_SELECT_RESET   8'h00

`define BLUE_OFFSET_MSB                7
`define BLUE_OFFSET_LSB                6
`define RED_OFFSET_MSB                 5
`define RED_OFFSET_LSB                 4
`define CHROMA_BW_BIT                  3
`define BW_TRADE_MSB                   2
`define COLOUR_FORCE_BIT               7
`define OUT1_INVERT_BIT                6
`define HS_POSITION_MSB                5
`define HS_POSITION_LSB                4
`define OUT0_INVERT_BIT                3
`define LUMA_DELAY_MSB                 2
`define OUT0_SELECT_MSB                3

`define CLK_PERIOD_NS                  100
`define LLC_STEP_NS                    200
`define LLC_STEP_CYCLES                ((`LLC_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: common/rt_output_mode_pkg.sv
package rt_output_mode_pkg;

    typedef enum logic [3:0] {
        SEL_HIGH_Z     = 4'h0,
        SEL_CONST_LOW  = 4'h1,
        SEL_PIXEL_QUAL = 4'h2,
        SEL_HALF_QUAL  = 4'h3,
        SEL_H_LOCK     = 4'h4,
        SEL_FULL_LOCK  = 4'h5,
        SEL_LOCK_COLOUR= 4'h6,
        SEL_RESERVED_A = 4'h7,
        SEL_LINE_REF   = 4'h8,
        SEL_HSYNC      = 4'h9,
        SEL_GATED_REF  = 4'ha,
        SEL_RESERVED_B = 4'hb,
        SEL_VSYNC      = 4'hc,
        SEL_VWINDOW    = 4'hd,
        SEL_ADC_LSB    = 4'he,
        SEL_FIELD      = 4'hf
    } rt_select_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_access_type;

    typedef struct packed {
        logic pixel_qualifier;
        logic hsync;
        logic active_line_ref;
        logic vertical_window;
        logic composite_vsync;
        logic field_parity;
        logic adc_lsb;
        logic h_lock_standard;
        logic h_lock_fast;
        logic v_lock;
        logic colour_detected;
        logic killer_colour_off;
    } timing_in_type;

    typedef struct packed {
        logic [1:0] blue_diff_fine_offset;
        logic [1:0] red_diff_fine_offset;
        logic       chroma_bw_select;
        logic [2:0] luma_chroma_bw_trade;
        logic       colour_enable;
        logic [1:0] hsync_fine_position;
        logic [2:0] luma_delay_comp;
        logic       rt_out1_invert;
    } config_out_type;

endpackage : rt_output_mode_pkg

// File: rtl/rt_output_mode_control.sv
`timescale 1ns/100ps
`include "rt_output_mode_control_defines.svh"

module rt_output_mode_control
    import rt_output_mode_pkg::*;
#(
    parameter int HS_STEPS_MAX = 3
) (
    input  wire logic           clk_in,
    input  wire logic           rst_b_in,
    input  wire reg_access_type reg_in,
    input  wire timing_in_type  timing_in,
    input  wire logic           lock_speed_select_in,
    output logic [7:0]          reg_rdata_out,
    output config_out_type      cfg_out,
    output logic                rt_output_pin0_out,
    output logic                rt_output_pin0_oe_out
);

    localparam int PIPE_LEN = HS_STEPS_MAX * `LLC_STEP_CYCLES;

    typedef struct packed {
        logic [7:0]          chroma_r;
        logic [7:0]          mode_r;
        logic [7:0]          select_r;
        logic [PIPE_LEN-1:0] hs_pipe_r;
        logic                qual_prev_r;
        logic                half_qual_r;
        logic                colour_en_r;
        logic                pin_r;
        logic                pin_oe_r;
        logic [7:0]          rdata_r;
    } state_type;

    state_type st_r;
    state_type st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // tap of the sync delay line for a given position step count
    function automatic logic hs_tap(input logic [PIPE_LEN-1:0] pipe,
                                    input logic [1:0]          steps,
                                    input logic                now);
        int idx;
        idx = int'(steps) * `LLC_STEP_CYCLES;
        if (idx == 0) begin
            hs_tap = now;
        end else begin
            hs_tap = pipe[idx-1];
        end
    endfunction : hs_tap

    function automatic logic [7:0] reg_read(input state_type s,
                                            input logic [7:0] addr);
        unique case (addr)
            `CHROMA_CONTROL_TWO_OFFSET:     reg_read = s.chroma_r;
            `MODE_DELAY_CONTROL_OFFSET:     reg_read = s.mode_r;
            `REALTIME_OUTPUT_SELECT_OFFSET: reg_read = s.select_r;
            default:                        reg_read = 8'h00;
        endcase
    endfunction : reg_read

    ////////////////////////////////////////////////////////////////////////////
    // field views

    logic [1:0]    hs_pos;
    logic          out0_inv;
    rt_select_type sel0;
    logic          h_lock;
    logic          full_lock;
    logic          lock_colour;
    logic          hs_delayed;
    logic          src;

    assign hs_pos    = st_r.mode_r[`HS_POSITION_MSB:`HS_POSITION_LSB];
    assign out0_inv  = st_r.mode_r[`OUT0_INVERT_BIT];
    assign sel0      = rt_select_type'(st_r.select_r[`OUT0_SELECT_MSB:0]);

    // fast lock reacts sooner but chatters on unstable timebases
    assign h_lock      = lock_speed_select_in ? timing_in.h_lock_fast
                                              : timing_in.h_lock_standard;
    assign full_lock   = h_lock & timing_in.v_lock;
    assign lock_colour = full_lock & timing_in.colour_detected;
    assign hs_delayed  = hs_tap(st_r.hs_pipe_r, hs_pos, timing_in.hsync);

    always_comb begin
        unique case (sel0)
            SEL_HIGH_Z:      src = 1'b0;
            SEL_CONST_LOW:   src = 1'b0;
            SEL_PIXEL_QUAL:  src = timing_in.pixel_qualifier;
            SEL_HALF_QUAL:   src = st_r.half_qual_r;
            SEL_H_LOCK:      src = h_lock;
            SEL_FULL_LOCK:   src = full_lock;
            SEL_LOCK_COLOUR: src = lock_colour;
            SEL_LINE_REF:    src = timing_in.active_line_ref;
            SEL_HSYNC:       src = hs_delayed;
            SEL_GATED_REF:   src = timing_in.active_line_ref
                                 & timing_in.vertical_window;
            SEL_VSYNC:       src = timing_in.composite_vsync;
            SEL_VWINDOW:     src = timing_in.vertical_window;
            SEL_ADC_LSB:     src = timing_in.adc_lsb;
            SEL_FIELD:       src = timing_in.field_parity;
            // reserved codes drive low rather than float
            default:         src = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_nxt = st_r;
        if (reg_in.wr) begin
            unique case (reg_in.addr)
                `CHROMA_CONTROL_TWO_OFFSET:     st_nxt.chroma_r = reg_in.wdata;
                `MODE_DELAY_CONTROL_OFFSET:     st_nxt.mode_r   = reg_in.wdata;
                `REALTIME_OUTPUT_SELECT_OFFSET: st_nxt.select_r = reg_in.wdata;
                default:                        st_nxt.rdata_r  = st_r.rdata_r;
            endcase
        end
        if (reg_in.rd) begin
            st_nxt.rdata_r = reg_read(st_r, reg_in.addr);
        end
        st_nxt.hs_pipe_r   = {st_r.hs_pipe_r[PIPE_LEN-2:0], timing_in.hsync};
        st_nxt.qual_prev_r = timing_in.pixel_qualifier;
        if (timing_in.pixel_qualifier && !st_r.qual_prev_r) begin
            st_nxt.half_qual_r = !st_r.half_qual_r;
        end
        st_nxt.colour_en_r = st_r.mode_r[`COLOUR_FORCE_BIT]
                           | !timing_in.killer_colour_off;
        st_nxt.pin_r    = src ^ out0_inv;
        st_nxt.pin_oe_r = (sel0 != SEL_HIGH_Z);
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_r          <= '0;
            st_r.chroma_r <= `CHROMA_CONTROL_TWO_RESET;
            st_r.mode_r   <= `MODE_DELAY_CONTROL_RESET;
            st_r.select_r <= `REALTIME_OUTPUT_SELECT_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata_out         = st_r.rdata_r;
    assign rt_output_pin0_out    = st_r.pin_r;
    assign rt_output_pin0_oe_out = st_r.pin_oe_r;

    assign cfg_out.blue_diff_fine_offset = st_r.chroma_r[`BLUE_OFFSET_MSB:`BLUE_OFFSET_LSB];
    assign cfg_out.red_diff_fine_offset  = st_r.chroma_r[`RED_OFFSET_MSB:`RED_OFFSET_LSB];
    assign cfg_out.chroma_bw_select      = st_r.chroma_r[`CHROMA_BW_BIT];
    assign cfg_out.luma_chroma_bw_trade  = st_r.chroma_r[`BW_TRADE_MSB:0];
    assign cfg_out.colour_enable         = st_r.colour_en_r;
    assign cfg_out.rt_out1_invert        = st_r.mode_r[`OUT1_INVERT_BIT];
    assign cfg_out.hsync_fine_position   = hs_pos;
    // two's complement, read as signed steps by the luma path
    assign cfg_out.luma_delay_comp       = st_r.mode_r[`LUMA_DELAY_MSB:0];

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_high_z_idle: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sel0 == SEL_HIGH_Z |=> !rt_output_pin0_oe_out)
        else $error("pin driven while high-z selected");

    a_const_low_drive: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sel0 == SEL_CONST_LOW |=> rt_output_pin0_oe_out
                                  && rt_output_pin0_out == $past(out0_inv))
        else $error("constant low code wrong");

    a_lock_select: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sel0 == SEL_H_LOCK && lock_speed_select_in && !out0_inv
        |=> rt_output_pin0_out == $past(timing_in.h_lock_fast))
        else $error("fast lock not selected");

    a_lock_colour_and: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sel0 == SEL_LOCK_COLOUR && !timing_in.colour_detected
        |=> rt_output_pin0_out == $past(out0_inv))
        else $error("lock flag high without colour");

    a_gated_ref_and: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sel0 == SEL_GATED_REF && !timing_in.vertical_window && out0_inv
        |=> rt_output_pin0_out)
        else $error("line reference not gated");

    a_hs_fine_delay: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sel0 == SEL_HSYNC && hs_pos == 2'd2 && !out0_inv
        |=> rt_output_pin0_out == $past(timing_in.hsync, 5))
        else $error("sync position delay wrong");

    a_half_rate_toggle: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        timing_in.pixel_qualifier && !st_r.qual_prev_r
        |=> st_r.half_qual_r != $past(st_r.half_qual_r))
        else $error("half-rate qualifier missed toggle");

    a_colour_forced: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        st_r.mode_r[`COLOUR_FORCE_BIT] |=> cfg_out.colour_enable)
        else $error("colour not forced on");

    a_mode_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        reg_in.wr && reg_in.addr == `MODE_DELAY_CONTROL_OFFSET
        |=> cfg_out.luma_delay_comp == $past(reg_in.wdata[2:0]))
        else $error("mode register write lost");

    a_pixel_qual_pass: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sel0 == SEL_PIXEL_QUAL
        |=> rt_output_pin0_out == ($past(timing_in.pixel_qualifier) ^ $past(out0_inv)))
        else $error("pixel qualifier not on pin");

    a_half_qual_pass: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sel0 == SEL_HALF_QUAL
        |=> rt_output_pin0_out == ($past(st_r.half_qual_r) ^ $past(out0_inv)))
        else $error("half-rate qualifier not on pin");

    a_lock_standard: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sel0 == SEL_H_LOCK && !lock_speed_select_in
        |=> rt_output_pin0_out == ($past(timing_in.h_lock_standard) ^ $past(out0_inv)))
        else $error("standard lock not selected");

    a_h_lock_pass: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sel0 == SEL_H_LOCK
        |=> rt_output_pin0_out == ($past(h_lock) ^ $past(out0_inv)))
        else $error("lock indicator not on pin");

    a_full_lock_and: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sel0 == SEL_FULL_LOCK
        |=> rt_output_pin0_out == ($past(h_lock & timing_in.v_lock) ^ $past(out0_inv)))
        else $error("full lock flag wrong");

    a_line_ref_pass: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sel0 == SEL_LINE_REF
        |=> rt_output_pin0_out == ($past(timing_in.active_line_ref) ^ $past(out0_inv)))
        else $error("line reference not on pin");

    a_hsync_no_shift: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sel0 == SEL_HSYNC && hs_pos == 2'd0
        |=> rt_output_pin0_out == ($past(timing_in.hsync) ^ $past(out0_inv)))
        else $error("unshifted sync wrong");

    a_hs_max_delay: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sel0 == SEL_HSYNC && hs_pos == 2'd3
        |=> rt_output_pin0_out == ($past(timing_in.hsync, 7) ^ $past(out0_inv)))
        else $error("largest sync shift wrong");

    a_gated_ref_pass: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sel0 == SEL_GATED_REF
        |=> rt_output_pin0_out == ($past(timing_in.active_line_ref & timing_in.vertical_window) ^ $past(out0_inv)))
        else $error("gated reference wrong");

    a_vsync_pass: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sel0 == SEL_VSYNC
        |=> rt_output_pin0_out == ($past(timing_in.composite_vsync) ^ $past(out0_inv)))
        else $error("vertical sync not on pin");

    a_vwindow_pass: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sel0 == SEL_VWINDOW
        |=> rt_output_pin0_out == ($past(timing_in.vertical_window) ^ $past(out0_inv)))
        else $error("vertical window not on pin");

    a_adc_lsb_pass: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sel0 == SEL_ADC_LSB
        |=> rt_output_pin0_out == ($past(timing_in.adc_lsb) ^ $past(out0_inv)))
        else $error("converter bit not on pin");

    a_field_pass: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sel0 == SEL_FIELD
        |=> rt_output_pin0_out == ($past(timing_in.field_parity) ^ $past(out0_inv)))
        else $error("field parity not on pin");

    a_reserved_low: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sel0 == SEL_RESERVED_A || sel0 == SEL_RESERVED_B
        |=> rt_output_pin0_out == $past(out0_inv))
        else $error("reserved code not low");

    a_drive_enable: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sel0 != SEL_HIGH_Z
        |=> rt_output_pin0_oe_out)
        else $error("pin not driven");

    a_killer_active: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !st_r.mode_r[`COLOUR_FORCE_BIT]
        |=> cfg_out.colour_enable == !$past(timing_in.killer_colour_off))
        else $error("colour killer ignored");

    a_blue_offset: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        reg_in.wr && reg_in.addr == `CHROMA_CONTROL_TWO_OFFSET
        |=> cfg_out.blue_diff_fine_offset == $past(reg_in.wdata[7:6]))
        else $error("blue offset write lost");

    a_red_offset: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        reg_in.wr && reg_in.addr == `CHROMA_CONTROL_TWO_OFFSET
        |=> cfg_out.red_diff_fine_offset == $past(reg_in.wdata[5:4]))
        else $error("red offset write lost");

    a_chroma_bw: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        reg_in.wr && reg_in.addr == `CHROMA_CONTROL_TWO_OFFSET
        |=> cfg_out.chroma_bw_select == $past(reg_in.wdata[3]))
        else $error("chroma bandwidth write lost");

    a_bw_trade: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        reg_in.wr && reg_in.addr == `CHROMA_CONTROL_TWO_OFFSET
        |=> cfg_out.luma_chroma_bw_trade == $past(reg_in.wdata[2:0]))
        else $error("bandwidth trade write lost");

    a_out1_invert: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        reg_in.wr && reg_in.addr == `MODE_DELAY_CONTROL_OFFSET
        |=> cfg_out.rt_out1_invert == $past(reg_in.wdata[6]))
        else $error("second output polarity lost");

    a_out0_invert: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        reg_in.wr && reg_in.addr == `MODE_DELAY_CONTROL_OFFSET
        |=> out0_inv == $past(reg_in.wdata[3]))
        else $error("first output polarity lost");

    a_hs_pos_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        reg_in.wr && reg_in.addr == `MODE_DELAY_CONTROL_OFFSET
        |=> cfg_out.hsync_fine_position == $past(reg_in.wdata[5:4]))
        else $error("sync position write lost");

    a_select_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        reg_in.wr && reg_in.addr == `REALTIME_OUTPUT_SELECT_OFFSET
        |=> sel0 == $past(reg_in.wdata[3:0]))
        else $error("select write lost");

    a_select_read: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        reg_in.rd && reg_in.addr == `REALTIME_OUTPUT_SELECT_OFFSET
        |=> reg_rdata_out == $past(st_r.select_r))
        else $error("select readback wrong");

    a_mode_read: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        reg_in.rd && reg_in.addr == `MODE_DELAY_CONTROL_OFFSET
        |=> reg_rdata_out == $past(st_r.mode_r))
        else $error("mode readback wrong");

    a_unmapped_ignored: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        reg_in.wr && reg_in.addr > `REALTIME_OUTPUT_SELECT_OFFSET
        |=> $stable(st_r.chroma_r) && $stable(st_r.mode_r) && $stable(st_r.select_r))
        else $error("unmapped write changed a register");

endmodule : rt_output_mode_control

// File: tb/rt_output_mode_control_test.sv
`timescale 1ns/100ps
`include "rt_output_mode_control_defines.svh"

module rt_output_mode_control_test
    import rt_output_mode_pkg::*;
;
    logic           clk_in;
    logic           rst_b_in;
    logic           lock_speed_select_in;
    reg_access_type reg_in;
    timing_in_type  timing_in;
    logic [7:0]     reg_rdata_out;
    config_out_type cfg_out;
    logic           pin;
    logic           oe;
    int             num_errors;
    int             check_count;
    int             cycles;
    int             settle;
    logic [7:0]     mreg [3];
    logic [31:0]    seed;
    timing_in_type  hist [$];
    logic           ls_hist [$];
    logic           p1;
    logic           p2;
    logic [7:0]     v;

    rt_output_mode_control #(.HS_STEPS_MAX(3)) i_dut (
        .clk_in                (clk_in),
        .rst_b_in              (rst_b_in),
        .reg_in                (reg_in),
        .timing_in             (timing_in),
        .lock_speed_select_in  (lock_speed_select_in),
        .reg_rdata_out         (reg_rdata_out),
        .cfg_out               (cfg_out),
        .rt_output_pin0_out    (pin),
        .rt_output_pin0_oe_out (oe)
    );

    function logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task report_and_stop;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        if (a >= 8'h10 && a <= 8'h12) begin
            mreg[a - 8'h10] = d;
        end
        settle = 8;
        @(posedge clk_in);
        reg_in.wr <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        reg_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        reg_in.rd <= 1'b0;
        @(negedge clk_in);
        d = reg_rdata_out;
    endtask : rd

    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    ////////////////////////////////////////////////////////////////
    // random sources; qualifier toggles every clock like the pixel rate
    always @(posedge clk_in) begin : drive
        timing_in_type t;
        cycles <= cycles + 1;
        if (cycles > 20000) begin
            num_errors++;
            report_and_stop();
        end
        seed = xorshift(seed);
        t = {~timing_in.pixel_qualifier, seed[10:0]};
        // lock sources agree here since the combined flags may use either
        if (mreg[2][3:0] inside {4'h5, 4'h6}) begin
            t.h_lock_fast = t.h_lock_standard;
        end
        timing_in <= t;
        lock_speed_select_in <= seed[20];
    end

    ////////////////////////////////////////////////////////////////
    // reference model of the pin, checked each cycle once sources settle
    always @(negedge clk_in) begin : watch
        logic e;
        logic hl;
        if (settle > 0) begin
            settle--;
        end else if (hist.size() == 8) begin
            hl = ls_hist[0] ? hist[0].h_lock_fast : hist[0].h_lock_standard;
            case (rt_select_type'(mreg[2][3:0]))
                SEL_PIXEL_QUAL:  e = hist[0].pixel_qualifier;
                SEL_HALF_QUAL:   e = ~p2 ^ mreg[1][3];
                SEL_H_LOCK:      e = hl;
                SEL_FULL_LOCK:   e = hl & hist[0].v_lock;
                SEL_LOCK_COLOUR: e = hl & hist[0].v_lock & hist[0].colour_detected;
                SEL_LINE_REF:    e = hist[0].active_line_ref;
                SEL_HSYNC:       e = hist[2 * mreg[1][5:4]].hsync;
                SEL_GATED_REF:   e = hist[0].active_line_ref & hist[0].vertical_window;
                SEL_VSYNC:       e = hist[0].composite_vsync;
                SEL_VWINDOW:     e = hist[0].vertical_window;
                SEL_ADC_LSB:     e = hist[0].adc_lsb;
                SEL_FIELD:       e = hist[0].field_parity;
                default:         e = 1'b0;
            endcase
            check({7'h00, pin}, {7'h00, e ^ mreg[1][3]}, "pin");
            check({7'h00, oe}, {7'h00, mreg[2][3:0] != 4'h0}, "oe");
            check({7'h00, cfg_out.colour_enable}, {7'h00, mreg[1][7] | ~hist[0].killer_colour_off}, "colour");
        end
        p2 = p1;
        p1 = pin;
        hist.push_front(timing_in);
        ls_hist.push_front(lock_speed_select_in);
        if (hist.size() > 8) begin
            void'(hist.pop_back());
            void'(ls_hist.pop_back());
        end
    end

    initial begin
        reg_in = '0;
        timing_in = '0;
        lock_speed_select_in = 1'b0;
        rst_b_in = 1'b0;
        seed = 32'd3867;
        num_errors = 0;
        check_count = 0;
        cycles = 0;
        settle = 16;
        mreg = '{default: 8'h00};
        p1 = 1'b0;
        p2 = 1'b0;
        repeat (10) @(posedge clk_in);
        check({7'h00, oe}, 8'h00, "oe in reset");
        rst_b_in <= 1'b1;
        for (int a = 0; a < 4; a++) begin
            rd(8'h10 + a[7:0], v);
            check(v, 8'h00, "reset value");
        end
        // every field code, with an unmapped write squeezed in between
        for (int i = 0; i < 8; i++) begin
            wr(`CHROMA_CONTROL_TWO_OFFSET, {i[1:0], ~i[1:0], i[0], i[2:0]});
            wr(`MODE_DELAY_CONTROL_OFFSET, {i[0], ~i[0], i[1:0], i[1], i[2:0]});
            wr(8'h13, 8'hff);
            @(negedge clk_in);
            check({cfg_out.blue_diff_fine_offset, cfg_out.red_diff_fine_offset, cfg_out.chroma_bw_select,
                   cfg_out.luma_chroma_bw_trade}, mreg[0], "cfg chroma");
            check({2'b00, cfg_out.rt_out1_invert, cfg_out.hsync_fine_position, cfg_out.luma_delay_comp},
                  {2'b00, mreg[1][6:4], mreg[1][2:0]}, "cfg mode");
            for (int a = 0; a < 4; a++) begin
                rd(8'h10 + a[7:0], v);
                check(v, (a < 3) ? mreg[a] : 8'h00, "readback");
            end
        end
        // all select codes, both polarities, every sync position
        for (int s = 0; s < 16; s++) begin
            for (int k = 0; k < 8; k++) begin
                wr(`MODE_DELAY_CONTROL_OFFSET, {k[0], k[1], k[1:0], k[2], k[2:0]});
                wr(`REALTIME_OUTPUT_SELECT_OFFSET, {4'h0, s[3:0]});
                repeat (14) @(posedge clk_in);
            end
        end
        report_and_stop();
    end
endmodule : rt_output_mode_control_test
